// ===== amp_regs_defines.vh
// Constants for the fault, clipper and digital control register slice
// Assumes inclusion by bare name from the design file
`ifndef AMP_REGS_DEFINES_VH
`define AMP_REGS_DEFINES_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_FAULT 8'h08
`define OFS_CLIP_HIGH 8'h10
`define OFS_CLIP_LOW 8'h11
`define OFS_DIG_CTRL3 8'h13
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_FAULT_CFG 2'h0
`define RST_CLIP_HIGH 8'h01
`define RST_CLIP_LOW 6'h01
`define RST_DIG_CTRL3 8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FLD_OCTH_HI 5
`define FLD_OCTH_LO 4
`define FLD_HPF_HI 7
`define FLD_HPF_LO 5
`define FLD_SLEEP_HI 4
`define FLD_SLEEP_LO 3
`define FLD_SLOT16 2
`define FLD_MCLK_SRC 1
`define FLD_VOL_LSB 0
`define FLD_CLIPL_HI 7
`define FLD_CLIPL_LO 2
`define FLD_CLOCK_ERROR_FLAG 3
`define FLD_OCE 2
`define FLD_DCE 1
`define FLD_OTE 0
`define FAULT_EVT_N 3
// ----------------------------------------
// Idle sleep codes and frame counts; clip width and sample sign bit
// ----------------------------------------
`define SLEEP_CNT_W 18
`define SLEEP_CODE_OFF 2'h0
`define SLEEP_CODE_1K 2'h1
`define SLEEP_CODE_64K 2'h2
`define SLEEP_N_1K 18'h003FF
`define SLEEP_N_64K 18'h0FFFF
`define SLEEP_N_256K 18'h3FFFF
`define CLIP_W 20
`define SAMPLE_SIGN 19
`endif

// ===== amp_fault_clip_filter_regs.v
// Fault status, clipper level, high-pass and digital control 3 registers
// Assumes an I2C slave front end gives byte strobes; detectors give levels
// Function
// RULE1: two-bit threshold select picks 100, 75, 50, 25 percent; resets to full
// RULE2: bit 3 shows present clock errors, clears itself, zero after reset
// RULE3: bit 2 latches over-current event and holds it
// RULE4: bit 1 latches DC detect error and holds it
// RULE5: bit 0 latches over-temperature error and holds it
// RULE6: host writes zero into reserved bits 7 to 6 of fault register
// RULE7: upper clipper register holds clipper level bits 13 to 6
// RULE8: lower clipper register bits 7 to 2 hold clipper level bits 5 to 0
// RULE9: sample magnitude sent to DAC never exceeds clipper level
// RULE10: host writes zero into reserved bits 1 to 0 of lower clipper register
// RULE11: three-bit high-pass corner select in bits 7 to 5, zero after reset
// RULE12: idle sleep after 1K, 64K or 256K zero frames; code 00 disables
// RULE13: bit 2 set selects 16-bit slots, clear selects 24 or 32
// RULE14: bit 1 selects master clock pin, clear derives it from bit clock
// RULE15: bit 0 is the volume setting least significant bit
// RULE16: latched fault flags clear only on device reset
// RULE17: writes to status bits 3 to 0 are ignored
`timescale 1ns/100ps
`include "amp_regs_defines.vh"
`default_nettype none
module amp_fault_clip_filter_regs (
   // Clock and reset
   input wire CLOCK,
   input wire RST_N,
   // Register access from control port
   input wire REG_WR,
   input wire REG_RD,
   input wire [7:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   output reg [7:0] REG_RDATA,
   // Detector levels
   input wire CLK_ERR_IN,
   input wire OVERCURRENT_IN,
   input wire DC_DETECT_IN,
   input wire OVERTEMP_IN,
   // Audio sample path
   input wire FRAME_STROBE,
   input wire [19:0] SAMPLE_IN,
   output reg [19:0] SAMPLE_OUT,
   // Settings to datapath and power stage
   output reg [1:0] OVERCURRENT_THRESHOLD_SEL,
   output reg [19:0] CLIP_LIMIT_VALUE,
   output reg [2:0] HIGHPASS_CORNER_SEL,
   output reg SHORT_SLOT_WIDTH,
   output reg MCLK_FROM_PIN,
   output reg VOLUME_LSB,
   output reg POWER_STAGE_SLEEP
);
   // ----------------------------------------
   // Register state
   // ----------------------------------------
   reg [1:0] overcurrent_threshold_sel_q;
   reg [7:0] clip_high_q;
   reg [5:0] clip_low_q;
   reg [7:0] dig_ctrl3_q;
   reg clock_error_flag_q;
   reg [2:0] sticky_flag_q;
   wire [2:0] sticky_event;
   wire [2:0] sticky_flag_d;
   wire overcurrent_flag;
   wire dc_detect_flag;
   wire overtemp_flag;
   genvar g;
   reg [17:0] idle_cnt_q;
   reg [17:0] idle_limit;
   reg [7:0] rdata_d;
   reg [19:0] clip_d;
   wire [19:0] clip_level;
   wire sample_neg;
   wire [19:0] sample_mag;

   // Address match helper
   function hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   // ----------------------------------------
   // Host register writes
   // ----------------------------------------
   // Host writes; only writable fields stored
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         overcurrent_threshold_sel_q <= `RST_FAULT_CFG;
         clip_high_q <= `RST_CLIP_HIGH;
         clip_low_q <= `RST_CLIP_LOW;
         dig_ctrl3_q <= `RST_DIG_CTRL3;
      end else if (REG_WR) begin
         if (hit(REG_ADDR, `OFS_FAULT))
            overcurrent_threshold_sel_q <= REG_WDATA[`FLD_OCTH_HI:`FLD_OCTH_LO]; // RULE1 RULE17
         if (hit(REG_ADDR, `OFS_CLIP_HIGH))
            clip_high_q <= REG_WDATA; // RULE7
         if (hit(REG_ADDR, `OFS_CLIP_LOW))
            clip_low_q <= REG_WDATA[`FLD_CLIPL_HI:`FLD_CLIPL_LO]; // RULE8
         if (hit(REG_ADDR, `OFS_DIG_CTRL3))
            dig_ctrl3_q <= REG_WDATA; // RULE11
      end
   end

   // ----------------------------------------
   // Fault flags
   // ----------------------------------------
   // Detector events packed in status bit order
   assign sticky_event = {OVERCURRENT_IN, DC_DETECT_IN, OVERTEMP_IN};

   // Event flags hold once set; nothing but reset clears them
   generate
      for (g = 0; g < `FAULT_EVT_N; g = g + 1) begin : sticky_gen
         assign sticky_flag_d[g] = sticky_flag_q[g] | sticky_event[g]; // RULE3 RULE4 RULE5
      end
   endgenerate

   // Named views of the latched flags
   assign overcurrent_flag = sticky_flag_q[`FLD_OCE];
   assign dc_detect_flag = sticky_flag_q[`FLD_DCE];
   assign overtemp_flag = sticky_flag_q[`FLD_OTE];

   // Clock error follows its detector; event flags latch until reset
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         clock_error_flag_q <= 1'b0;
         sticky_flag_q <= 3'h0;
      end else begin
         clock_error_flag_q <= CLK_ERR_IN; // RULE2
         sticky_flag_q <= sticky_flag_d; // RULE16
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // Read mux; reserved bits read as zero
   always @* begin
      rdata_d = 8'h00;
      if (hit(REG_ADDR, `OFS_FAULT)) begin
         rdata_d[`FLD_OCTH_HI:`FLD_OCTH_LO] = overcurrent_threshold_sel_q;
         rdata_d[`FLD_CLOCK_ERROR_FLAG] = clock_error_flag_q; // RULE2
         rdata_d[`FLD_OCE] = overcurrent_flag; // RULE3
         rdata_d[`FLD_DCE] = dc_detect_flag; // RULE4
         rdata_d[`FLD_OTE] = overtemp_flag; // RULE5
      end else if (hit(REG_ADDR, `OFS_CLIP_HIGH))
         rdata_d = clip_high_q;
      else if (hit(REG_ADDR, `OFS_CLIP_LOW))
         rdata_d[`FLD_CLIPL_HI:`FLD_CLIPL_LO] = clip_low_q;
      else if (hit(REG_ADDR, `OFS_DIG_CTRL3))
         rdata_d = dig_ctrl3_q;
   end

   // Read data register, updated on read strobe
   always @(posedge CLOCK) begin
      if (!RST_N)
         REG_RDATA <= 8'h00;
      else if (REG_RD)
         REG_RDATA <= rdata_d;
   end

   // ----------------------------------------
   // Digital clipper
   // ----------------------------------------
   assign clip_level = {6'h00, clip_high_q, clip_low_q}; // RULE7 RULE8
   assign sample_neg = SAMPLE_IN[`SAMPLE_SIGN];
   assign sample_mag = sample_neg ? (~SAMPLE_IN + 20'h00001) : SAMPLE_IN;

   // Clamp magnitude, keep sign
   always @* begin
      if (sample_mag > clip_level)
         clip_d = sample_neg ? (~clip_level + 20'h00001) : clip_level; // RULE9
      else
         clip_d = SAMPLE_IN;
   end

   // ----------------------------------------
   // Idle sleep
   // ----------------------------------------
   // Idle sleep limit decode
   always @* begin
      case (dig_ctrl3_q[`FLD_SLEEP_HI:`FLD_SLEEP_LO])
         `SLEEP_CODE_1K: idle_limit = `SLEEP_N_1K;
         `SLEEP_CODE_64K: idle_limit = `SLEEP_N_64K;
         default: idle_limit = `SLEEP_N_256K;
      endcase
   end

   // Zero-frame counter and sleep output
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         idle_cnt_q <= 18'h00000;
         POWER_STAGE_SLEEP <= 1'b0;
      end else if (dig_ctrl3_q[`FLD_SLEEP_HI:`FLD_SLEEP_LO] == `SLEEP_CODE_OFF) begin
         idle_cnt_q <= 18'h00000; // RULE12
         POWER_STAGE_SLEEP <= 1'b0;
      end else if (FRAME_STROBE) begin
         if (SAMPLE_IN != 20'h00000) begin
            idle_cnt_q <= 18'h00000;
            POWER_STAGE_SLEEP <= 1'b0;
         end else if (idle_cnt_q >= idle_limit) begin
            POWER_STAGE_SLEEP <= 1'b1; // RULE12
         end else begin
            idle_cnt_q <= idle_cnt_q + 18'h00001;
         end
      end
   end

   // ----------------------------------------
   // Settings outputs
   // ----------------------------------------
   // Registered settings outputs and clipped sample
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         SAMPLE_OUT <= 20'h00000;
         OVERCURRENT_THRESHOLD_SEL <= `RST_FAULT_CFG;
         CLIP_LIMIT_VALUE <= 20'h00000;
         HIGHPASS_CORNER_SEL <= 3'h0;
         SHORT_SLOT_WIDTH <= 1'b0;
         MCLK_FROM_PIN <= 1'b0;
         VOLUME_LSB <= 1'b0;
      end else begin
         if (FRAME_STROBE)
            SAMPLE_OUT <= clip_d; // RULE9
         OVERCURRENT_THRESHOLD_SEL <= overcurrent_threshold_sel_q; // RULE1
         CLIP_LIMIT_VALUE <= clip_level;
         HIGHPASS_CORNER_SEL <= dig_ctrl3_q[`FLD_HPF_HI:`FLD_HPF_LO]; // RULE11
         SHORT_SLOT_WIDTH <= dig_ctrl3_q[`FLD_SLOT16]; // RULE13
         MCLK_FROM_PIN <= dig_ctrl3_q[`FLD_MCLK_SRC]; // RULE14
         VOLUME_LSB <= dig_ctrl3_q[`FLD_VOL_LSB]; // RULE15
      end
   end
endmodule // amp_fault_clip_filter_regs
`default_nettype wire

// ===== amp_regs_checker.sv
// Assertions on the register slice ports
// Assumes binding to the register block top
`timescale 1ns/100ps
`default_nettype none
module amp_regs_checker (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // Register strobes and buses
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   // Detector levels
   input wire logic CLK_ERR_IN,
   input wire logic OVERCURRENT_IN,
   // Audio path
   input wire logic FRAME_STROBE,
   input wire logic [19:0] SAMPLE_IN,
   input wire logic [19:0] SAMPLE_OUT,
   // Settings
   input wire logic [19:0] CLIP_LIMIT_VALUE,
   input wire logic [2:0] HIGHPASS_CORNER_SEL,
   input wire logic [1:0] OVERCURRENT_THRESHOLD_SEL,
   input wire logic SHORT_SLOT_WIDTH,
   input wire logic MCLK_FROM_PIN,
   input wire logic VOLUME_LSB,
   input wire logic POWER_STAGE_SLEEP
);
   logic oc_q;
   // Decoded strobes and compared fields
   wire r08 = REG_RD && REG_ADDR == 8'h08;
   wire w08 = REG_WR && REG_ADDR == 8'h08;
   wire w10 = REG_WR && REG_ADDR == 8'h10;
   wire w11 = REG_WR && REG_ADDR == 8'h11;
   wire w13 = REG_WR && REG_ADDR == 8'h13;
   wire [5:0] ctl = {HIGHPASS_CORNER_SEL, SHORT_SLOT_WIDTH, MCLK_FROM_PIN, VOLUME_LSB};
   wire [5:0] wdc = {REG_WDATA[7:5], REG_WDATA[2:0]};
   wire signed [20:0] so = $signed(SAMPLE_OUT);
   wire signed [20:0] lim = {1'b0, CLIP_LIMIT_VALUE};
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   // Any over-current seen since reset
   always_ff @(posedge CLOCK) oc_q <= RST_N & (oc_q | OVERCURRENT_IN);
   a_oce_latch: assert property (r08 |=> REG_RDATA[2] == $past(oc_q))
      else $error("overcurrent flag wrong");
   a_clock_error_flag_live: assert property (r08 |=> REG_RDATA[3] == $past(CLK_ERR_IN, 2))
      else $error("clock error flag wrong");
   a_fault_resv: assert property (r08 |=> REG_RDATA[7:6] == 2'h0)
      else $error("reserved fault bits set");
   a_octh_map: assert property (w08 |=> ##1 OVERCURRENT_THRESHOLD_SEL == $past(REG_WDATA[5:4], 2))
      else $error("threshold not applied");
   a_cliph_map: assert property (w10 |=> ##1 CLIP_LIMIT_VALUE[13:6] == $past(REG_WDATA, 2))
      else $error("upper clip bits wrong");
   a_clipl_map: assert property (w11 |=> ##1 CLIP_LIMIT_VALUE[5:0] == $past(REG_WDATA[7:2], 2))
      else $error("lower clip bits wrong");
   a_ctrl3_map: assert property (w13 |=> ##1 ctl == $past(wdc, 2))
      else $error("control fields wrong");
   a_clamp_mag: assert property (FRAME_STROBE |=> so <= lim && so >= -lim)
      else $error("sample above clip level");
   a_sleep_wake: assert property (FRAME_STROBE && SAMPLE_IN != 20'h00000 |=> !POWER_STAGE_SLEEP)
      else $error("sleep with live audio");
   c_sleep: cover property (POWER_STAGE_SLEEP);
   c_clip: cover property (FRAME_STROBE ##1 SAMPLE_OUT == CLIP_LIMIT_VALUE);
   c_oce: cover property (r08 ##1 REG_RDATA[2]);
endmodule // amp_regs_checker
`default_nettype wire

// ===== amp_host_model.sv
// Host side of the register strobe port
// Assumes tasks are called just after a falling clock edge
`timescale 1ns/100ps
`default_nettype none
module amp_host_model (
   // Clock and read data
   input wire logic CLOCK,
   input wire logic [7:0] REG_RDATA,
   // Strobes, address and write data
   output logic REG_WR = 1'b0,
   output logic REG_RD = 1'b0,
   output logic [7:0] REG_ADDR = 8'h00,
   output logic [7:0] REG_WDATA = 8'h00
);
   // One write strobe, reserved bits sent as zero
   task wr(input logic [7:0] a, d);
      REG_ADDR = a;
      REG_WDATA = a == 8'h08 ? d & 8'h3F : a == 8'h11 ? d & 8'hFC : d;
      REG_WR = 1'b1;
      @(negedge CLOCK) REG_WR = 1'b0;
      @(negedge CLOCK);
   endtask
   // One read strobe, data taken a cycle later
   task rd(input logic [7:0] a, output logic [7:0] q);
      REG_ADDR = a;
      REG_RD = 1'b1;
      @(negedge CLOCK) REG_RD = 1'b0;
      @(negedge CLOCK) q = REG_RDATA;
   endtask
endmodule // amp_host_model
`default_nettype wire

// ===== amp_fault_clip_filter_regs_tb.sv
// Bench for the fault, clipper and control register slice
// Assumes the host model and checker are compiled first
`timescale 1ns/100ps
`default_nettype none
`define H amp_host_model_i
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module amp_fault_clip_filter_regs_tb;
   logic CLOCK = 1'b0, RST_N = 1'b0, FRAME_STROBE = 1'b0, CLK_ERR_IN = 1'b0, OVERCURRENT_IN = 1'b0;
   logic DC_DETECT_IN = 1'b0, OVERTEMP_IN = 1'b0, REG_WR, REG_RD;
   logic SHORT_SLOT_WIDTH, MCLK_FROM_PIN, VOLUME_LSB, POWER_STAGE_SLEEP;
   logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, q;
   logic [19:0] SAMPLE_IN = 20'h00000, SAMPLE_OUT, CLIP_LIMIT_VALUE;
   logic [2:0] HIGHPASS_CORNER_SEL;
   logic [1:0] OVERCURRENT_THRESHOLD_SEL;
   logic [7:0] ofs [5] = '{8'h08, 8'h10, 8'h11, 8'h13, 8'h12};
   logic [7:0] rst_v [5] = '{8'h00, 8'h01, 8'h04, 8'h00, 8'h00};
   int fail_count = 0, compares = 0, cycles = 0;
   wire [5:0] ctl = {HIGHPASS_CORNER_SEL, SHORT_SLOT_WIDTH, MCLK_FROM_PIN, VOLUME_LSB};
   amp_fault_clip_filter_regs amp_fault_clip_filter_regs_i (
      .CLOCK(CLOCK),
      .RST_N(RST_N),
      .REG_WR(REG_WR),
      .REG_RD(REG_RD),
      .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA),
      .CLK_ERR_IN(CLK_ERR_IN),
      .OVERCURRENT_IN(OVERCURRENT_IN),
      .DC_DETECT_IN(DC_DETECT_IN),
      .OVERTEMP_IN(OVERTEMP_IN),
      .FRAME_STROBE(FRAME_STROBE),
      .SAMPLE_IN(SAMPLE_IN),
      .SAMPLE_OUT(SAMPLE_OUT),
      .OVERCURRENT_THRESHOLD_SEL(OVERCURRENT_THRESHOLD_SEL),
      .CLIP_LIMIT_VALUE(CLIP_LIMIT_VALUE),
      .HIGHPASS_CORNER_SEL(HIGHPASS_CORNER_SEL),
      .SHORT_SLOT_WIDTH(SHORT_SLOT_WIDTH),
      .MCLK_FROM_PIN(MCLK_FROM_PIN),
      .VOLUME_LSB(VOLUME_LSB),
      .POWER_STAGE_SLEEP(POWER_STAGE_SLEEP)
   );
   amp_host_model amp_host_model_i (.CLOCK, .REG_RDATA, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA);
   always #12.5 CLOCK = ~CLOCK;
   // Verdict and end of run
   task print_verdict;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Cycle ceiling against a hang
   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 80000) begin
         fail_count++;
         print_verdict;
      end
   end
   // One frame with the strobe held high
   task frame(input logic [19:0] s, e);
      SAMPLE_IN = s;
      FRAME_STROBE = 1'b1;
      @(negedge CLOCK) `CHK("sample", e, SAMPLE_OUT)
   endtask
   initial begin
      repeat (16) @(negedge CLOCK);
      RST_N = 1'b1;
      @(negedge CLOCK);
      foreach (ofs[i]) begin
         `H.rd(ofs[i], q);
         `CHK("reset", rst_v[i], q)
      end
      `CHK("clip", 20'h00041, CLIP_LIMIT_VALUE)
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         `H.wr(8'h08, {2'h3, i[1:0], 4'hF});
         `CHK("octh", i[1:0], OVERCURRENT_THRESHOLD_SEL)
         `H.rd(8'h08, q);
         `CHK("fault", {2'h0, i[1:0], 4'h0}, q)
      end
      {CLK_ERR_IN, OVERCURRENT_IN, DC_DETECT_IN, OVERTEMP_IN} = 4'hF;
      @(negedge CLOCK) {OVERCURRENT_IN, DC_DETECT_IN, OVERTEMP_IN} = 3'h0;
      repeat (3) @(negedge CLOCK);
      `H.rd(8'h08, q);
      `CHK("flags", 8'h3F, q)
      CLK_ERR_IN = 1'b0;
      repeat (3) @(negedge CLOCK);
      `H.rd(8'h08, q);
      `CHK("flags", 8'h37, q)
      // Mid-run reset clears latched flags and threshold
      RST_N = 1'b0;
      repeat (2) @(negedge CLOCK);
      RST_N = 1'b1;
      @(negedge CLOCK);
      `H.rd(8'h08, q);
      `CHK("rst flags", 8'h00, q)
      `CHK("rst clip", 20'h00041, CLIP_LIMIT_VALUE)
      $display("fault test done");
      for (int i = 0; i < 8; i++) begin
         `H.wr(8'h13, {i[2:0], 2'h0, i[2:0]});
         `CHK("ctrl3", {i[2:0], i[2:0]}, ctl)
      end
      `H.wr(8'h10, 8'hFF);
      `H.wr(8'h11, 8'hFF);
      `H.rd(8'h11, q);
      `CHK("clipl", 8'hFC, q)
      `CHK("clip", 20'h03FFF, CLIP_LIMIT_VALUE)
      `H.wr(8'h10, 8'h04);
      `H.wr(8'h11, 8'h00);
      frame(20'h003E8, 20'h00100);
      frame(20'hFFC18, 20'hFFF00);
      frame(20'h00064, 20'h00064);
      $display("clip test done");
      `H.wr(8'h13, 8'h08);
      SAMPLE_IN = 20'h00000;
      repeat (1000) @(negedge CLOCK);
      `CHK("sleep", 1'b0, POWER_STAGE_SLEEP)
      repeat (100) @(negedge CLOCK);
      `CHK("sleep", 1'b1, POWER_STAGE_SLEEP)
      `H.wr(8'h13, 8'h00);
      `CHK("off", 1'b0, POWER_STAGE_SLEEP)
      repeat (1100) @(negedge CLOCK);
      `CHK("off", 1'b0, POWER_STAGE_SLEEP)
      `H.wr(8'h13, 8'h10);
      repeat (65530) @(negedge CLOCK);
      `CHK("sleep64", 1'b0, POWER_STAGE_SLEEP)
      repeat (10) @(negedge CLOCK);
      `CHK("sleep64", 1'b1, POWER_STAGE_SLEEP)
      frame(20'h00005, 20'h00005);
      `CHK("wake", 1'b0, POWER_STAGE_SLEEP)
      `H.wr(8'h13, 8'h18);
      SAMPLE_IN = 20'h00000;
      repeat (1100) @(negedge CLOCK);
      `CHK("sleep256", 1'b0, POWER_STAGE_SLEEP)
      FRAME_STROBE = 1'b0;
      $display("sleep test done");
      print_verdict;
   end
endmodule // amp_fault_clip_filter_regs_tb
bind amp_fault_clip_filter_regs amp_regs_checker amp_regs_checker_i (
   .CLOCK(CLOCK),
   .RST_N(RST_N),
   .REG_WR(REG_WR),
   .REG_RD(REG_RD),
   .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA),
   .REG_RDATA(REG_RDATA),
   .CLK_ERR_IN(CLK_ERR_IN),
   .OVERCURRENT_IN(OVERCURRENT_IN),
   .FRAME_STROBE(FRAME_STROBE),
   .SAMPLE_IN(SAMPLE_IN),
   .SAMPLE_OUT(SAMPLE_OUT),
   .CLIP_LIMIT_VALUE(CLIP_LIMIT_VALUE),
   .HIGHPASS_CORNER_SEL(HIGHPASS_CORNER_SEL),
   .OVERCURRENT_THRESHOLD_SEL(OVERCURRENT_THRESHOLD_SEL),
   .SHORT_SLOT_WIDTH(SHORT_SLOT_WIDTH),
   .MCLK_FROM_PIN(MCLK_FROM_PIN),
   .VOLUME_LSB(VOLUME_LSB),
   .POWER_STAGE_SLEEP(POWER_STAGE_SLEEP)
);
`default_nettype wire
